// *** hdl/tx_parallel_phase_fifo.sv ***
// Purpose: Transmit input FIFO from the parallel input clock to word clock
// Assumes: Input clock is sampled on ref_clk; word clock is ref_clk / 16
// Notes:   A two-entry output buffer absorbs receiver stalls
`timescale 1ns/10ps
module tx_parallel_phase_fifo (
  // Clock and reset
  input  logic                            ref_clk,
  input  logic                            nrst,
  input  logic                            clk_en,
  // Parallel input side
  input  logic                            parallel_input_clock,
  input  logic [tx_fifo_pkg::WORD_W-1:0]  tx_word,
  input  logic                            fifo_init_request,
  output logic                            phase_error_flag,
  output logic                            word_clock_out,
  // PLL status
  input  logic                            pll_locked,
  output logic                            pll_lock_indicator,
  // Serializer side
  output logic                            out_valid,
  input  logic                            out_ready,
  output logic [tx_fifo_pkg::WORD_W-1:0]  out_data
);

  logic [tx_fifo_pkg::WORD_W-1:0] mem [tx_fifo_pkg::FIFO_DEPTH];

  tx_fifo_pkg::phase_state_t         state_reg;
  tx_fifo_pkg::phase_state_t         state_next;
  tx_fifo_pkg::slot_t                buf0_reg;
  tx_fifo_pkg::slot_t                buf1_reg;
  tx_fifo_pkg::slot_t                buf0_next;
  tx_fifo_pkg::slot_t                buf1_next;
  tx_fifo_pkg::slot_t                new_slot;
  logic [tx_fifo_pkg::DIV_W-1:0]     div_reg;
  logic [tx_fifo_pkg::PTR_W-1:0]     wr_reg;
  logic [tx_fifo_pkg::PTR_W-1:0]     rd_reg;
  logic [tx_fifo_pkg::PTR_W-1:0]     wr_next;
  logic [tx_fifo_pkg::PTR_W-1:0]     rd_next;
  logic [tx_fifo_pkg::PTR_W-1:0]     rd_inc;
  logic [tx_fifo_pkg::PTR_W-1:0]     rd_centre;
  logic [tx_fifo_pkg::PTR_W-1:0]     occ;
  logic [1:0]                        edge_cnt_reg;
  logic [1:0]                        req_cnt_reg;
  logic [2:0]                        init_cnt_reg;
  logic                              pic_d_reg;
  logic                              lock_reg;
  logic                              lock_ok;
  logic                              flag_reg;
  logic                              flag_next;
  logic                              in_edge;
  logic                              word_tick;
  logic                              near_violation;
  logic                              auto_centre;
  logic                              init_done;
  logic                              centre_now;
  logic                              req_met;
  logic                              reading;
  logic                              rd_go;
  logic                              buf_in_ready;
  logic                              pop;

  // Edge of the sampled input clock and the divided word clock
  assign in_edge   = parallel_input_clock & ~pic_d_reg;
  assign word_tick = (div_reg == tx_fifo_pkg::DIV_LAST);

  // Occupancy modulo depth; the centre is half the depth
  assign occ = (wr_reg >= rd_reg) ? (wr_reg - rd_reg)
                                  : (wr_reg + tx_fifo_pkg::PTR_DEPTH - rd_reg);
  assign near_violation = (occ <= tx_fifo_pkg::OCC_LOW_MARK) ||
                          (occ >= tx_fifo_pkg::OCC_HI_MARK);

  assign wr_next = !in_edge ? wr_reg :
                   (wr_reg == tx_fifo_pkg::PTR_LAST) ? tx_fifo_pkg::PTR_ZERO
                                                     : wr_reg + tx_fifo_pkg::PTR_ONE;
  // Three behind the next write, so half the depth apart
  assign rd_centre = (wr_next >= tx_fifo_pkg::PTR_CENTRE)
                     ? wr_next - tx_fifo_pkg::PTR_CENTRE
                     : wr_next + tx_fifo_pkg::PTR_CENTRE;
  assign rd_inc = (rd_reg == tx_fifo_pkg::PTR_LAST) ? tx_fifo_pkg::PTR_ZERO
                                                    : rd_reg + tx_fifo_pkg::PTR_ONE;

  // Steps need the pin and its copy, so no state outlives a lost lock
  assign lock_ok     = lock_reg && pll_locked;
  assign auto_centre = (state_reg == tx_fifo_pkg::ST_AUTO_WAIT) && in_edge &&
                       lock_ok &&
                       (edge_cnt_reg == tx_fifo_pkg::AUTO_EDGE_LAST);
  assign init_done   = (state_reg == tx_fifo_pkg::ST_INIT_WAIT) && word_tick &&
                       (init_cnt_reg == tx_fifo_pkg::INIT_TICKS_LAST);
  assign centre_now  = auto_centre || init_done;
  // Request must be seen high on two consecutive word clocks
  assign req_met     = (state_reg == tx_fifo_pkg::ST_RUN) && word_tick &&
                       fifo_init_request && lock_ok &&
                       (req_cnt_reg == tx_fifo_pkg::REQ_TICKS_LAST);

  // Reads follow the word clock only; words in flight at a recentre are lost
  assign reading = (state_reg == tx_fifo_pkg::ST_RUN) ||
                   (state_reg == tx_fifo_pkg::ST_INIT_WAIT);
  assign rd_go   = reading && word_tick && buf_in_ready && !centre_now;
  assign rd_next = centre_now ? rd_centre : (rd_go ? rd_inc : rd_reg);

  // Flag only after the first centring, so earlier delay is free
  // In run the flag latches: occupancy ripples by one word each word clock,
  // and a flickering flag would never be seen at two word clocks in a row
  assign flag_next = (state_reg == tx_fifo_pkg::ST_RUN) ?
                     (flag_reg || near_violation) :
                     (state_reg == tx_fifo_pkg::ST_INIT_WAIT) ? !init_done :
                     1'b0;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      tx_fifo_pkg::ST_WAIT_LOCK: begin
        if (lock_reg) begin
          state_next = tx_fifo_pkg::ST_AUTO_WAIT;
        end
      end
      tx_fifo_pkg::ST_AUTO_WAIT: begin
        if (auto_centre) begin
          state_next = tx_fifo_pkg::ST_RUN;
        end
      end
      tx_fifo_pkg::ST_RUN: begin
        if (req_met) begin
          state_next = tx_fifo_pkg::ST_INIT_WAIT;
        end
      end
      tx_fifo_pkg::ST_INIT_WAIT: begin
        if (init_done) begin
          state_next = tx_fifo_pkg::ST_RUN;
        end
      end
      default: begin
        state_next = tx_fifo_pkg::ST_WAIT_LOCK;
      end
    endcase
    if (!lock_ok) begin
      state_next = tx_fifo_pkg::ST_WAIT_LOCK;
    end
  end

  // Two-entry output buffer; the head always sits in buf0
  assign new_slot     = '{valid: 1'b1, data: mem[rd_reg]};
  assign buf_in_ready = !buf1_reg.valid;
  assign pop          = buf0_reg.valid && out_ready;
  assign buf0_next = pop ? (buf1_reg.valid ? buf1_reg :
                            (rd_go ? new_slot : tx_fifo_pkg::SLOT_EMPTY)) :
                     (rd_go && !buf0_reg.valid) ? new_slot : buf0_reg;
  assign buf1_next = pop ? ((rd_go && buf1_reg.valid) ? new_slot
                                                      : tx_fifo_pkg::SLOT_EMPTY) :
                     (rd_go && buf0_reg.valid) ? new_slot : buf1_reg;

  assign out_valid          = buf0_reg.valid;
  assign out_data           = buf0_reg.data;
  assign phase_error_flag   = flag_reg;
  assign pll_lock_indicator = lock_reg;
  assign word_clock_out     = div_reg[tx_fifo_pkg::DIV_W-1];

  // Divider runs from reset, so the load strobe is fixed to the reference
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= '0;
    end else if (clk_en) begin
      div_reg <= div_reg + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (clk_en && in_edge) begin
      mem[wr_reg] <= tx_word;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wr_reg    <= '0;
      rd_reg    <= '0;
      pic_d_reg <= 1'b0;
      lock_reg  <= 1'b0;
      flag_reg  <= 1'b0;
      state_reg <= tx_fifo_pkg::ST_WAIT_LOCK;
    end else if (clk_en) begin
      wr_reg    <= wr_next;
      rd_reg    <= rd_next;
      pic_d_reg <= parallel_input_clock;
      lock_reg  <= pll_locked;
      flag_reg  <= flag_next;
      state_reg <= state_next;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      edge_cnt_reg <= tx_fifo_pkg::CNT2_ZERO;
      req_cnt_reg  <= tx_fifo_pkg::CNT2_ZERO;
      init_cnt_reg <= tx_fifo_pkg::CNT3_ZERO;
    end else if (clk_en) begin
      if (state_reg != tx_fifo_pkg::ST_AUTO_WAIT) begin
        edge_cnt_reg <= tx_fifo_pkg::CNT2_ZERO;
      end else if (in_edge) begin
        edge_cnt_reg <= edge_cnt_reg + tx_fifo_pkg::CNT2_ONE;
      end
      if (!fifo_init_request) begin
        req_cnt_reg <= tx_fifo_pkg::CNT2_ZERO;
      end else if (word_tick && req_cnt_reg != tx_fifo_pkg::REQ_TICKS_MET) begin
        req_cnt_reg <= req_cnt_reg + tx_fifo_pkg::CNT2_ONE;
      end
      if (state_reg != tx_fifo_pkg::ST_INIT_WAIT) begin
        init_cnt_reg <= tx_fifo_pkg::CNT3_ZERO;
      end else if (word_tick) begin
        init_cnt_reg <= init_cnt_reg + tx_fifo_pkg::CNT3_ONE;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      buf0_reg <= tx_fifo_pkg::SLOT_EMPTY;
      buf1_reg <= tx_fifo_pkg::SLOT_EMPTY;
    end else if (clk_en) begin
      buf0_reg <= buf0_next;
      buf1_reg <= buf1_next;
    end
  end

  a_write_on_edge: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && in_edge) |=> (wr_reg != $past(wr_reg)))
    else $error("write pointer did not advance on input clock edge");

  a_read_held: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && !word_tick && !centre_now) |=> $stable(rd_reg))
    else $error("read pointer moved off the word clock");

  a_read_once: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && rd_go) |=> (rd_reg != $past(rd_reg)) && out_valid)
    else $error("read did not advance or deliver a word");

  a_divider_wrap: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && word_tick) |=> (div_reg == '0) && !word_clock_out)
    else $error("word clock divider did not wrap after sixteen");

  a_flag_persist: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && state_reg == tx_fifo_pkg::ST_RUN && near_violation)
    |=> phase_error_flag)
    else $error("phase error flag missing on imminent violation");

  a_lock_gates: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_reg != tx_fifo_pkg::ST_WAIT_LOCK) |-> pll_lock_indicator)
    else $error("FIFO active without lock indication");

  a_auto_third: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && auto_centre)
    |=> (state_reg == tx_fifo_pkg::ST_RUN) && (occ == tx_fifo_pkg::PTR_CENTRE))
    else $error("FIFO not centred on third input edge");

  a_quiet_before: assert property (@(posedge ref_clk) disable iff (!nrst)
    (state_reg == tx_fifo_pkg::ST_AUTO_WAIT) |-> !phase_error_flag)
    else $error("phase error raised before first centring");

  a_req_two: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && req_met) |=> (state_reg == tx_fifo_pkg::ST_INIT_WAIT))
    else $error("two word clock request did not start initialization");

  a_init_done: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && init_done)
    |=> !phase_error_flag && (occ == tx_fifo_pkg::PTR_CENTRE))
    else $error("flag high or pointers off centre after initialization");

  a_buffer_hold: assert property (@(posedge ref_clk) disable iff (!nrst)
    (out_valid && !out_ready) |=> out_valid && $stable(out_data))
    else $error("stalled output word changed or vanished");

  a_flag_latched: assert property (@(posedge ref_clk) disable iff (!nrst)
    (clk_en && state_reg == tx_fifo_pkg::ST_RUN && phase_error_flag)
    |=> phase_error_flag)
    else $error("phase error flag dropped without initialization");

  a_init_window: assert property (@(posedge ref_clk)
    disable iff (!nrst || !clk_en || !pll_lock_indicator)
    (clk_en && req_met) |-> ##[32:128] init_done)
    else $error("initialization not complete in two to eight word clocks");

  a_lock_follow: assert property (@(posedge ref_clk) disable iff (!nrst)
    clk_en |=> (pll_lock_indicator == $past(pll_locked)))
    else $error("lock indication does not follow the PLL lock input");

endmodule

// *** inc/tx_fifo_pkg.sv ***
// Purpose: Shared constants and types for the transmit phase FIFO
// Assumes: One clock; word clock is an enable derived by division
// Notes:   Pointers count modulo the FIFO depth
package tx_fifo_pkg;

  localparam int unsigned WORD_W      = 16;
  localparam int unsigned FIFO_DEPTH  = 6;
  localparam int unsigned PTR_W       = 3;
  localparam int unsigned DIV_W       = 4;

  localparam logic [DIV_W-1:0] DIV_LAST     = 4'hF;
  localparam logic [PTR_W-1:0] PTR_LAST     = 3'h5;
  localparam logic [PTR_W-1:0] PTR_ZERO     = 3'h0;
  localparam logic [PTR_W-1:0] PTR_ONE      = 3'h1;
  localparam logic [PTR_W-1:0] PTR_CENTRE   = 3'h3;
  localparam logic [PTR_W-1:0] PTR_DEPTH    = 3'h6;
  localparam logic [PTR_W-1:0] OCC_LOW_MARK = 3'h1;
  localparam logic [PTR_W-1:0] OCC_HI_MARK  = 3'h5;

  localparam logic [1:0] AUTO_EDGE_LAST  = 2'h2;
  localparam logic [1:0] REQ_TICKS_LAST  = 2'h1;
  localparam logic [1:0] REQ_TICKS_MET   = 2'h2;
  localparam logic [1:0] CNT2_ZERO       = 2'h0;
  localparam logic [1:0] CNT2_ONE        = 2'h1;
  localparam logic [2:0] INIT_TICKS_LAST = 3'h3;
  localparam logic [2:0] CNT3_ZERO       = 3'h0;
  localparam logic [2:0] CNT3_ONE        = 3'h1;

  typedef enum logic [1:0] {
    ST_WAIT_LOCK = 2'b00,
    ST_AUTO_WAIT = 2'b01,
    ST_RUN       = 2'b10,
    ST_INIT_WAIT = 2'b11
  } phase_state_t;

  typedef struct packed {
    logic              valid;
    logic [WORD_W-1:0] data;
  } slot_t;

  localparam slot_t SLOT_EMPTY = '{valid: 1'b0, data: 16'h0000};

endpackage

// *** tb/asic_partner.sv ***
// Purpose: Customer logic model feeding the transmit FIFO
// Assumes: Input clock period is sixteen ref_clk cycles
// Notes:   Handshake mode; slip stops the input clock
`timescale 1ns/10ps
module asic_partner (
  // Clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           nrst,
  // Bench control
  input  wire logic                           run,
  input  wire logic                           slip,
  input  wire logic                           man_req,
  // Device side
  input  wire logic                           phase_error_flag,
  output logic                                parallel_input_clock,
  output logic [tx_fifo_pkg::WORD_W-1:0]      tx_word,
  output logic                                fifo_init_request
);
  logic [3:0]  phase_reg;
  logic [15:0] seq_reg;
  logic        hs_reg;
  // Clock stands low while not running
  assign parallel_input_clock = run & phase_reg[3];
  assign fifo_init_request = man_req | hs_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= 4'h0;
      seq_reg <= 16'h1001;
      hs_reg <= 1'b0;
      tx_word <= 16'h1000;
    end else begin
      hs_reg <= phase_error_flag;
      if (!run) begin
        tx_word <= ~tx_word;
      end else if (!slip) begin
        phase_reg <= phase_reg + 4'h1;
        // Word changes half a period before the rising edge
        if (phase_reg == 4'hF) begin
          if (phase_error_flag) begin
            tx_word <= 16'h0000;
          end else begin
            tx_word <= seq_reg;
            seq_reg <= seq_reg + 16'h0001;
          end
        end
      end
    end
  end
endmodule

// *** tb/tx_parallel_phase_fifo_test.sv ***
// Purpose: Self-checking bench for the transmit phase FIFO
// Assumes: Word clock and input clock both every 16 ref_clk cycles
// Notes:   A monitor checks the popped stream is gap free
`timescale 1ns/10ps
module tx_parallel_phase_fifo_test;
  typedef struct packed {logic [7:0] stall; logic flag;} row_t;
  localparam row_t ROWS [3] = '{'{8'h00, 1'b0}, '{8'h08, 1'b0},
                                '{8'h18, 1'b0}};
  logic        ref_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        clk_en = 1'b1;
  logic        pll_locked = 1'b0;
  logic        out_ready = 1'b1;
  logic        run = 1'b0;
  logic        slip = 1'b0;
  logic        man_req = 1'b0;
  logic        pic, req, flag, wck, lock, out_valid;
  logic [15:0] tx_word, out_data, exp_word;
  logic [15:0] frz_data;
  logic [2:0]  frz_bits;
  logic        resync = 1'b1;
  int          err_count = 0;
  int          checked = 0;
  int          pops = 0;
  int          n, p0;
  always #4 ref_clk = ~ref_clk;
  tx_parallel_phase_fifo dut_u (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en),
    .parallel_input_clock(pic), .tx_word(tx_word),
    .fifo_init_request(req), .phase_error_flag(flag),
    .word_clock_out(wck), .pll_locked(pll_locked),
    .pll_lock_indicator(lock), .out_valid(out_valid),
    .out_ready(out_ready), .out_data(out_data));
  asic_partner partner_u (
    .ref_clk(ref_clk), .nrst(nrst), .run(run), .slip(slip),
    .man_req(man_req), .phase_error_flag(flag),
    .parallel_input_clock(pic), .tx_word(tx_word),
    .fifo_init_request(req));
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("Checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic wait_flag(input logic level, input int limit);
    n = 0;
    while (flag !== level && n < limit) begin
      @(negedge ref_clk);
      n++;
    end
  endtask
  // Idle words or lost lock mark a realignment; the next real word reseeds
  always @(posedge ref_clk) begin
    if (lock !== 1'b1) begin
      resync <= 1'b1;
    end else if (clk_en === 1'b1 && out_valid === 1'b1 &&
                 out_ready === 1'b1) begin
      pops++;
      if (out_data === 16'h0000) begin
        resync <= 1'b1;
      end else begin
        if (resync !== 1'b1) check("stream", out_data, exp_word);
        resync <= 1'b0;
        exp_word <= out_data + 16'h0001;
      end
    end
  end
  initial begin
    #100000;
    err_count++;
    conclude();
  end
  initial begin
    repeat (10) @(negedge ref_clk);
    check("rst_flag", {15'h0, flag}, 16'h0000);
    check("rst_lock", {15'h0, lock}, 16'h0000);
    check("rst_wck", {15'h0, wck}, 16'h0000);
    check("rst_valid", {15'h0, out_valid}, 16'h0000);
    check("rst_data", out_data, 16'h0000);
    @(posedge ref_clk);
    nrst <= 1'b1;
    run <= 1'b1;
    @(posedge ref_clk);
    pll_locked <= 1'b1;
    @(negedge ref_clk);
    check("lock_early", {15'h0, lock}, 16'h0000);
    @(negedge ref_clk);
    check("lock_on", {15'h0, lock}, 16'h0001);
    n = 0;
    repeat (16) begin
      @(negedge ref_clk);
      n += wck;
    end
    check("wck_high", 16'(n), 16'h0008);
    repeat (200) @(negedge ref_clk);
    check("flag_centred", {15'h0, flag}, 16'h0000);
    check("flowing", {15'h0, pops > 3}, 16'h0001);
    foreach (ROWS[i]) begin
      p0 = pops;
      if (ROWS[i].stall != 8'h00) begin
        @(posedge ref_clk);
        out_ready <= 1'b0;
        repeat (ROWS[i].stall) @(posedge ref_clk);
        out_ready <= 1'b1;
      end
      repeat (64) @(negedge ref_clk);
      check("row_flag", {15'h0, flag}, {15'h0, ROWS[i].flag});
      check("row_pops", {15'h0, pops > p0 + 2}, 16'h0001);
    end
    @(posedge ref_clk);
    man_req <= 1'b1;
    repeat (8) @(posedge ref_clk);
    man_req <= 1'b0;
    repeat (100) @(negedge ref_clk);
    check("short_req", {15'h0, flag}, 16'h0000);
    @(posedge ref_clk);
    man_req <= 1'b1;
    wait_flag(1'b1, 64);
    check("init_start", {15'h0, n < 40}, 16'h0001);
    @(posedge ref_clk);
    man_req <= 1'b0;
    wait_flag(1'b0, 200);
    check("init_done", {15'h0, n >= 16 && n < 130}, 16'h0001);
    repeat (100) @(negedge ref_clk);
    check("init_quiet", {15'h0, flag}, 16'h0000);
    // Freeze the block and stop the partner's clock for the same edges
    @(posedge ref_clk);
    clk_en <= 1'b0;
    slip <= 1'b1;
    @(negedge ref_clk);
    frz_data = out_data;
    frz_bits = {wck, flag, out_valid};
    repeat (16) @(posedge ref_clk);
    clk_en <= 1'b1;
    slip <= 1'b0;
    @(negedge ref_clk);
    check("frz_data", out_data, frz_data);
    check("frz_bits", {13'h0, wck, flag, out_valid}, {13'h0, frz_bits});
    @(posedge ref_clk);
    slip <= 1'b1;
    repeat (32) @(posedge ref_clk);
    slip <= 1'b0;
    wait_flag(1'b1, 64);
    check("slip_flag", {15'h0, flag}, 16'h0001);
    wait_flag(1'b0, 300);
    check("slip_clear", {15'h0, flag}, 16'h0000);
    repeat (100) @(negedge ref_clk);
    check("slip_quiet", {15'h0, flag}, 16'h0000);
    check("slip_flow", {15'h0, resync}, 16'h0000);
    // Lose lock in mid-run; the FIFO must wait and centre again
    p0 = pops;
    @(posedge ref_clk);
    pll_locked <= 1'b0;
    repeat (4) @(negedge ref_clk);
    check("unlock_ind", {15'h0, lock}, 16'h0000);
    check("unlock_flag", {15'h0, flag}, 16'h0000);
    @(posedge ref_clk);
    pll_locked <= 1'b1;
    repeat (150) @(negedge ref_clk);
    check("relock_flag", {15'h0, flag}, 16'h0000);
    check("relock_flow", {15'h0, pops > p0 + 3}, 16'h0001);
    check("relock_sync", {15'h0, resync}, 16'h0000);
    conclude();
  end
endmodule
